// ### rtl/wgo_cfg.svh
// timing counts, register offsets and field positions of the waveform output configuration
// assumes a single 40 MHz bus clock and AHB-Lite register access
// Notes on behaviour
// - load request ignores a set written together with enable; needs enable already 1.
// - clock select 0 picks system clock, 1 picks fast internal oscillator.
// - clock select sits in bit 0 and resets to 0.
// - clock select bits 7..1 read 0 and ignore writes.
// - data input select holds 4-bit selector, reset 0, upper bits unused.
// - selector codes map pin, comparators, capture units, pwms, osc, logic cells; 14,15 reserved.
// - in modes 0, 1 and 4 a steered output carries data input, else its manual level; polarity applies to both.
`ifndef WGO_CFG_SVH
`define WGO_CFG_SVH
`define WGO_CLK_MHZ 40
`define WGO_OFS_CON0 12'h000
`define WGO_OFS_CON1 12'h004
`define WGO_OFS_CLKCON 12'h008
`define WGO_OFS_DAT 12'h00c
`define WGO_OFS_STEER 12'h010
`define WGO_BIT_EN 7
`define WGO_BIT_LD 6
`define WGO_BIT_IN 5
`define WGO_BIT_CS 0
`define WGO_CON0_RST 8'h00
`define WGO_CON1_RST 8'h00
`define WGO_CLKCON_RST 8'h00
`define WGO_DAT_RST 8'h00
`define WGO_STEER_RST 8'h00
`define WGO_MODE_MASK 8'h07
`define WGO_POL_MASK 8'h0f
`define WGO_CS_MASK 8'h01
`define WGO_DAT_MASK 8'h0f
`define WGO_SRC_LAST 4'hd
`define WGO_NUM_SRC 14
`endif

// ### rtl/wgo_pkg.sv
// types shared by the waveform output configuration files
// assumes the constants header is included beside it
package wgo_pkg;
	typedef enum logic [1:0] {wgo_idle, wgo_data} wgo_phase_t;
	typedef logic [7:0] wgo_byte_t;
endpackage

// ### rtl/wgo_src_mux.sv
// registered data input source selector
// assumes source levels are synchronous to hclk
`timescale 1ns/100ps
`include "wgo_cfg.svh"
module wgo_src_mux
	import wgo_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] sel,
	input wire logic [13:0] sources,
	output logic level
);
	// ************
	// source pick
	// ************
	function automatic logic wgo_pick(input logic [3:0] s, input logic [13:0] v);
		logic r;
		r = 1'b0;
		if (s <= `WGO_SRC_LAST) begin
			r = v[s];
		end
		return r;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level <= 1'b0;
		end else begin
			level <= wgo_pick(sel, sources);
		end
	end

	a_reserved_low: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(sel) > `WGO_SRC_LAST |-> !level)
		else $error("reserved source did not read low");
endmodule

// ### rtl/wgo_top.sv
// register slice and output stage of the complementary waveform generator
// assumes an AHB-Lite master with single word transfers and synchronous source inputs
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "wgo_cfg.svh"
module wgo_top
	import wgo_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [13:0] sources,
	input wire logic [3:0] mode_wave,
	input wire logic load_done,
	output logic [3:0] wave_out,
	output logic clk_sel_fast,
	output logic module_enable,
	output logic buffer_load_request,
	output logic [2:0] mode_sel
);
	// ************
	// bus slave
	// ************
	wgo_phase_t phase;
	logic [11:0] addr_q;
	logic write_q;
	wgo_byte_t con0;
	wgo_byte_t polarity;
	wgo_byte_t clk_con;
	wgo_byte_t dat_sel;
	wgo_byte_t steer;
	logic data_in;
	logic [7:0] wd;
	logic rd_hold;

	// one wait state for a read that lands on a write data phase
	assign hreadyout = !rd_hold;
	assign hresp = 1'b0;
	assign wd = hwdata[7:0];

	function automatic logic wgo_hit(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= wgo_idle;
			addr_q <= 12'h000;
			write_q <= 1'b0;
		end else if (hready) begin
			if (hsel && htrans[1]) begin
				phase <= wgo_data;
				addr_q <= haddr;
				write_q <= hwrite;
			end else begin
				phase <= wgo_idle;
			end
		end
	end

	logic wr;
	assign wr = (phase == wgo_data) && write_q;

	// a read right behind a write waits until the write has landed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_hold <= 1'b0;
		end else begin
			rd_hold <= hready && hsel && htrans[1] && !hwrite && wr;
		end
	end

	// ************
	// control register 0
	// ************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			con0 <= `WGO_CON0_RST;
		end else begin
			if (wr && wgo_hit(addr_q, `WGO_OFS_CON0)) begin
				con0[`WGO_BIT_EN] <= wd[`WGO_BIT_EN];
				con0[2:0] <= wd[2:0];
			end
			if (load_done && !(wr && wgo_hit(addr_q, `WGO_OFS_CON0))) begin
				con0[`WGO_BIT_LD] <= 1'b0;
			end else if (wr && wgo_hit(addr_q, `WGO_OFS_CON0)) begin
				con0[`WGO_BIT_LD] <= wd[`WGO_BIT_LD] && con0[`WGO_BIT_EN];
			end
		end
	end

	// ************
	// polarity, clock, data and steering
	// ************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			polarity <= `WGO_CON1_RST;
		end else if (wr && wgo_hit(addr_q, `WGO_OFS_CON1)) begin
			polarity <= wd & `WGO_POL_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_con <= `WGO_CLKCON_RST;
		end else if (wr && wgo_hit(addr_q, `WGO_OFS_CLKCON)) begin
			clk_con <= wd & `WGO_CS_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dat_sel <= `WGO_DAT_RST;
		end else if (wr && wgo_hit(addr_q, `WGO_OFS_DAT)) begin
			dat_sel <= wd & `WGO_DAT_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			steer <= `WGO_STEER_RST;
		end else if (wr && wgo_hit(addr_q, `WGO_OFS_STEER)) begin
			steer <= wd;
		end
	end

	wgo_src_mux u_mux (
		.hclk(hclk),
		.hresetn(hresetn),
		.sel(dat_sel[3:0]),
		.sources(sources),
		.level(data_in)
	);

	// ************
	// read data
	// ************
	function automatic wgo_byte_t wgo_read(input logic [11:0] a);
		wgo_byte_t r;
		r = 8'h00;
		if (wgo_hit(a, `WGO_OFS_CON0)) begin
			r = con0;
		end else if (wgo_hit(a, `WGO_OFS_CON1)) begin
			r = polarity | {2'b00, data_in, 5'b00000};
		end else if (wgo_hit(a, `WGO_OFS_CLKCON)) begin
			r = clk_con;
		end else if (wgo_hit(a, `WGO_OFS_DAT)) begin
			r = dat_sel;
		end else if (wgo_hit(a, `WGO_OFS_STEER)) begin
			r = steer;
		end
		return r;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_hold) begin
			hrdata <= {24'h00_0000, wgo_read(addr_q)};
		end else if (hready && hsel && htrans[1] && !hwrite && !wr) begin
			hrdata <= {24'h00_0000, wgo_read(haddr)};
		end
	end

	// ************
	// output stage
	// ************
	logic [3:0] pre_pol;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (steer[i]) begin
				pre_pol[i] = data_in;
			end else begin
				pre_pol[i] = steer[4 + i];
			end
		end
	end

	logic [3:0] next_wave;
	assign next_wave = (con0[2:0] == 3'b100 || con0[2:0] == 3'b000 || con0[2:0] == 3'b001)
		? pre_pol : mode_wave;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wave_out <= 4'h0;
		end else begin
			wave_out <= next_wave ^ polarity[3:0];
		end
	end

	assign clk_sel_fast = clk_con[`WGO_BIT_CS];
	assign module_enable = con0[`WGO_BIT_EN];
	assign buffer_load_request = con0[`WGO_BIT_LD];
	assign mode_sel = con0[2:0];

	// ************
	// checks
	// ************
	a_load_needs_en: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(buffer_load_request) |-> $past(module_enable))
		else $error("load request set without prior enable");
	a_pol_last: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode_sel == 3'b000 && steer[0]) |=> wave_out[0] == ($past(data_in) ^ $past(polarity[0])))
		else $error("output polarity stage wrong");
	a_steer_manual: assert property (@(posedge hclk) disable iff (!hresetn)
		(!steer[0] && mode_sel == 3'b000) ##1 1 |-> wave_out[0] == ($past(steer[4]) ^ $past(polarity[0])))
		else $error("manual level not driven");
	a_clk_upper: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_con[7:1] == 7'h00)
		else $error("clock select upper bits set");
	a_clk_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		!(wr && wgo_hit(addr_q, `WGO_OFS_CLKCON)) |=> $stable(clk_sel_fast))
		else $error("clock select moved without a write");
	a_dat_upper: assert property (@(posedge hclk) disable iff (!hresetn)
		dat_sel[7:4] == 4'h0)
		else $error("data select upper bits set");
	a_pol_upper: assert property (@(posedge hclk) disable iff (!hresetn)
		wr && wgo_hit(addr_q, `WGO_OFS_CON1) |=> polarity == ($past(wd) & 8'h0f))
		else $error("polarity write lost");
	a_clk_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr && wgo_hit(addr_q, `WGO_OFS_CLKCON) |=> clk_con[0] == $past(wd[0]))
		else $error("clock select write lost");
	c_load_set: cover property (@(posedge hclk) disable iff (!hresetn) $rose(buffer_load_request));
	c_fast_clk: cover property (@(posedge hclk) disable iff (!hresetn) $rose(clk_sel_fast));
	c_inverted: cover property (@(posedge hclk) disable iff (!hresetn) polarity[3:0] == 4'hf);
	c_read_stall: cover property (@(posedge hclk) disable iff (!hresetn) rd_hold);
endmodule

// ### test/tb_waveform_gen_output_config.sv
// self-checking bench for the waveform output configuration slice
// assumes wgo_top may stall a read behind a write and reads back the low byte
`timescale 1ns/100ps
`include "wgo_cfg.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_waveform_gen_output_config;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic load_done = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [13:0] sources = 14'h0;
	logic [3:0] mode_wave = 4'h0;
	logic [31:0] rd;
	wire hreadyout, hresp, clk_sel_fast, module_enable, buffer_load_request;
	wire [31:0] hrdata;
	wire [3:0] wave_out;
	wire [2:0] mode_sel;
	int fails = 0;
	int compares = 0;
	wgo_top i_wgo_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sources(sources), .mode_wave(mode_wave), .load_done(load_done),
		.wave_out(wave_out), .clk_sel_fast(clk_sel_fast), .module_enable(module_enable),
		.buffer_load_request(buffer_load_request), .mode_sel(mode_sel));
	always #12.5 hclk = ~hclk;
	// ************************************
	// bus and helper tasks
	// ************************************
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask
	task automatic settle();
		repeat (2) @(posedge hclk);
		@(negedge hclk);
	endtask
	task automatic close_out();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ************************************
	// scenarios
	// ************************************
	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			xfer(12'(i * 4), 1'b0, 32'h0);
			`CHK(rd, 32'h0)
		end
		`CHK(clk_sel_fast, 1'b0)
		$display("test reset values done");
	endtask
	task automatic t_clk();
		xfer(`WGO_OFS_CLKCON, 1'b1, 32'hff);
		xfer(`WGO_OFS_CLKCON, 1'b0, 32'h0);
		`CHK(rd, 32'h1)
		`CHK(clk_sel_fast, 1'b1)
		xfer(`WGO_OFS_CLKCON, 1'b1, 32'hfe);
		xfer(`WGO_OFS_CLKCON, 1'b0, 32'h0);
		`CHK(rd, 32'h0)
		`CHK(clk_sel_fast, 1'b0)
		$display("test clock select done");
	endtask
	task automatic t_src();
		for (int c = 0; c < 16; c++) begin
			xfer(`WGO_OFS_DAT, 1'b1, {24'h0, 4'hf, 4'(c)});
			sources <= (c < 14) ? 14'h0001 << c : 14'h3fff;
			xfer(`WGO_OFS_DAT, 1'b0, 32'h0);
			`CHK(rd, {28'h0, 4'(c)})
			xfer(`WGO_OFS_CON1, 1'b0, 32'h0);
			`CHK(rd[5], (c < 14))
			sources <= ~(14'h0001 << c);
			xfer(`WGO_OFS_CON1, 1'b0, 32'h0);
			`CHK(rd[5], 1'b0)
		end
		$display("test source select done");
	endtask
	task automatic t_b2b();
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= `WGO_OFS_DAT;
		hwrite <= 1'b1;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hwrite <= 1'b0;
		hwdata <= 32'h9;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		@(negedge hclk);
		`CHK(hreadyout, 1'b0)
		do @(posedge hclk); while (hreadyout !== 1'b1);
		`CHK(hrdata, 32'h9)
		$display("test back to back done");
	endtask
	task automatic t_load();
		xfer(`WGO_OFS_CON0, 1'b1, 32'h40);
		xfer(`WGO_OFS_CON0, 1'b1, 32'hc0);
		@(negedge hclk);
		`CHK(module_enable, 1'b1)
		`CHK(buffer_load_request, 1'b0)
		xfer(`WGO_OFS_CON0, 1'b1, 32'hc0);
		@(negedge hclk);
		`CHK(buffer_load_request, 1'b1)
		@(posedge hclk);
		load_done <= 1'b1;
		@(posedge hclk);
		load_done <= 1'b0;
		@(negedge hclk);
		`CHK(buffer_load_request, 1'b0)
		$display("test load request done");
	endtask
	task automatic t_out();
		xfer(`WGO_OFS_STEER, 1'b1, 32'ha5);
		sources <= 14'h0;
		mode_wave <= 4'h6;
		xfer(`WGO_OFS_DAT, 1'b1, 32'h0);
		for (int m = 0; m < 8; m++) begin
			xfer(`WGO_OFS_CON0, 1'b1, {24'h0, 5'h10, 3'(m)});
			settle();
			`CHK(mode_sel, 3'(m))
			`CHK(wave_out, (m == 0 || m == 1 || m == 4) ? 4'ha : 4'h6)
		end
		xfer(`WGO_OFS_CON0, 1'b1, 32'h80);
		for (int p = 0; p < 16; p++) begin
			xfer(`WGO_OFS_CON1, 1'b1, {28'h0, 4'(p)});
			settle();
			`CHK(wave_out, 4'ha ^ 4'(p))
		end
		@(posedge hclk);
		sources <= 14'h0001;
		settle();
		`CHK(wave_out, 4'h0)
		xfer(`WGO_OFS_CON1, 1'b0, 32'h0);
		`CHK(rd, 32'h2f)
		xfer(12'h020, 1'b1, 32'hff);
		xfer(12'h020, 1'b0, 32'h0);
		`CHK(rd, 32'h0)
		$display("test output stage done");
	endtask
	// ************************************
	// main sequence and watchdog
	// ************************************
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_clk();
		t_src();
		t_b2b();
		t_load();
		t_out();
		close_out();
	end
	initial begin
		repeat (6000) @(posedge hclk);
		fails++;
		close_out();
	end
endmodule
